// file: rtl/dub_pkg.sv
// shared constants for the dual serial controller bus port
package dub_pkg;
	localparam int        DUB_CHANS      = 2;
	localparam int        DUB_DATA_W     = 8;
	localparam int        DUB_ADDR_W     = 3;
	localparam int        DUB_REGS       = 8;
	// register indices inside a channel
	localparam logic [2:0] DUB_REG_DATA   = 3'h0;
	localparam logic [2:0] DUB_REG_MDM    = 3'h4;
	localparam logic [2:0] DUB_REG_LSR    = 3'h5;
	localparam logic [2:0] DUB_REG_MSR    = 3'h6;
	// field positions
	localparam int        DUB_MDM_DTR    = 0;
	localparam int        DUB_MDM_RTS    = 1;
	localparam int        DUB_MDM_OUT2   = 3;
	localparam int        DUB_LSR_RXFULL = 0;
	localparam int        DUB_LSR_TXEMPT = 5;
	localparam int        DUB_MSR_CTS    = 4;
	localparam int        DUB_MSR_DSR    = 5;
	// values after reset
	localparam logic [7:0] DUB_REG_RST    = 8'h00;
	localparam logic [7:0] DUB_BUS_IDLE   = 8'hFF;
	// host timing in clock cycles
	localparam int        DUB_SETUP_CYC  = 2;
	localparam int        DUB_STROBE_CYC = 10;
	localparam int        DUB_HOLD_CYC   = 4;
	localparam int        DUB_STROBE_MIN = 8;
	localparam int        DUB_HOLD_MIN   = 4;
	localparam int        DUB_CNT_W      = 8;
	typedef enum logic [1:0] {DUB_IDLE, DUB_SETUP, DUB_STROBE, DUB_HOLD} dub_state_t;
endpackage

// file: rtl/dub_if.sv
// pin-level link between the host processor and the dual serial controller
interface dub_if;
	logic [2:0] addr;
	logic       read_strobe_n;
	logic       write_strobe_n;
	logic       chan_a_select_n;
	logic       chan_b_select_n;
	logic [7:0] host_data_out;
	logic       host_data_oe;
	logic [7:0] dev_data_out;
	logic       dev_data_oe;
	logic [7:0] data_bus;
	logic       chan_a_irq_out;
	logic       chan_b_irq_out;
	logic       chan_a_irq_oe;
	logic       chan_b_irq_oe;
	logic       chan_a_irq_line;
	logic       chan_b_irq_line;
	logic       chan_a_aux_out2_n;
	logic       chan_b_aux_out2_n;
	logic       chan_a_tx_ready_n;
	logic       chan_b_tx_ready_n;
	logic       chan_a_rx_ready_n;
	logic       chan_b_rx_ready_n;
	logic       chan_a_serial_out;
	logic       chan_b_serial_out;
	logic       chan_a_serial_in;
	logic       chan_b_serial_in;
	logic       chan_a_request_send_n;
	logic       chan_b_request_send_n;
	logic       chan_a_terminal_ready_n;
	logic       chan_b_terminal_ready_n;
	logic       chan_a_clear_send_n;
	logic       chan_b_clear_send_n;
	logic       chan_a_set_ready_n;
	logic       chan_b_set_ready_n;

	// bus has a weak pull-up; a floating interrupt line is pulled low
	assign data_bus = dev_data_oe ? dev_data_out :
		(host_data_oe ? host_data_out : 8'hFF);
	assign chan_a_irq_line = chan_a_irq_oe & chan_a_irq_out;
	assign chan_b_irq_line = chan_b_irq_oe & chan_b_irq_out;

	modport device (
		input  addr, read_strobe_n, write_strobe_n, chan_a_select_n, chan_b_select_n,
		input  data_bus,
		output dev_data_out, dev_data_oe,
		output chan_a_irq_out, chan_b_irq_out, chan_a_irq_oe, chan_b_irq_oe,
		output chan_a_aux_out2_n, chan_b_aux_out2_n,
		output chan_a_tx_ready_n, chan_b_tx_ready_n, chan_a_rx_ready_n, chan_b_rx_ready_n,
		output chan_a_serial_out, chan_b_serial_out,
		output chan_a_request_send_n, chan_b_request_send_n,
		output chan_a_terminal_ready_n, chan_b_terminal_ready_n,
		input  chan_a_serial_in, chan_b_serial_in,
		input  chan_a_clear_send_n, chan_b_clear_send_n,
		input  chan_a_set_ready_n, chan_b_set_ready_n
	);

	modport host (
		output addr, read_strobe_n, write_strobe_n, chan_a_select_n, chan_b_select_n,
		output host_data_out, host_data_oe,
		input  data_bus,
		input  chan_a_irq_line, chan_b_irq_line,
		input  chan_a_tx_ready_n, chan_b_tx_ready_n, chan_a_rx_ready_n, chan_b_rx_ready_n
	);
endinterface

// file: rtl/dub_device.sv
// device end: bus port, channel registers and channel pins of the dual serial controller
module dub_device
	import dub_pkg::*;
(
	// clock, reset, enable
	input  wire logic                  I_CLK,
	input  wire logic                  I_RST_N,
	input  wire logic                  I_CE,
	// host bus and channel pins
	dub_if.device                      BUS,
	// serial engine side, index 0 is channel A
	output logic [1:0]                 O_TX_VALID,
	output logic [1:0][7:0]            O_TX_BYTE,
	input  wire logic [1:0]            I_TX_TAKEN,
	input  wire logic [1:0][7:0]       I_RX_BYTE,
	input  wire logic [1:0]            I_RX_LOAD,
	input  wire logic [1:0]            I_IRQ_REQ,
	input  wire logic [1:0]            I_SERIAL_OUT,
	// sampled pins, serial in as its level, CTS and DSR inverted to active high
	output logic [1:0]                 O_SERIAL_IN,
	output logic [1:0]                 O_CTS,
	output logic [1:0]                 O_DSR
);
	import dub_pkg::*;

	localparam int SYNC_W = 21;

	// pin synchroniser
	logic [SYNC_W-1:0]      sync1;
	logic [SYNC_W-1:0]      sync2;
	logic [SYNC_W-1:0]      pins;

	// state
	logic [1:0][7:0][7:0]   regs;
	logic [1:0][7:0]        rx_hold;
	logic [1:0]             tx_full;
	logic [1:0]             rx_full;
	logic                   rd_prev;
	logic                   wr_prev;
	logic [7:0]             dev_do;
	logic                   dev_oe;
	logic [1:0]             irq_q;
	logic [1:0]             out2;
	logic [1:0]             rts;
	logic [1:0]             dtr;
	logic [1:0]             ser_out;

	logic [1:0][7:0][7:0]   next_regs;
	logic [1:0][7:0]        next_rx_hold;
	logic [1:0][7:0]        next_tx_byte;
	logic [1:0]             next_tx_full;
	logic [1:0]             next_rx_full;
	logic [7:0]             next_dev_do;
	logic                   next_dev_oe;
	logic [1:0]             next_out2;
	logic [1:0]             next_rts;
	logic [1:0]             next_dtr;

	// synchronised pin views
	logic                   rd_s;
	logic                   wr_s;
	logic [1:0]             sel;
	logic [2:0]             addr_s;
	logic [7:0]             data_s;
	logic [1:0]             ser_in_s;
	logic [1:0]             cts_s;
	logic [1:0]             dsr_s;
	logic                   rd_fall;
	logic                   wr_rise;
	logic                   rd_ch;
	logic [7:0]             rd_byte;

	assign pins = {BUS.read_strobe_n, BUS.write_strobe_n,
		BUS.chan_b_select_n, BUS.chan_a_select_n, BUS.addr, BUS.data_bus,
		BUS.chan_b_serial_in, BUS.chan_a_serial_in,
		BUS.chan_b_clear_send_n, BUS.chan_a_clear_send_n,
		BUS.chan_b_set_ready_n, BUS.chan_a_set_ready_n};

	assign rd_s     = sync2[20];
	assign wr_s     = sync2[19];
	assign sel      = ~sync2[18:17];
	assign addr_s   = sync2[16:14];
	assign data_s   = sync2[13:6];
	assign ser_in_s = sync2[5:4];
	assign cts_s    = ~sync2[3:2];
	assign dsr_s    = ~sync2[1:0];

	assign rd_fall  = rd_prev & ~rd_s;
	assign wr_rise  = ~wr_prev & wr_s;
	// with both selects low a read answers from channel A
	assign rd_ch    = ~sel[0];

	// byte presented for the addressed register of the selected channel
	always_comb begin
		rd_byte = regs[rd_ch][addr_s];
		unique case (addr_s)
			DUB_REG_DATA: begin
				rd_byte = rx_hold[rd_ch];
			end
			DUB_REG_LSR: begin
				rd_byte                 = 8'h00;
				rd_byte[DUB_LSR_RXFULL] = rx_full[rd_ch];
				rd_byte[DUB_LSR_TXEMPT] = ~tx_full[rd_ch];
			end
			DUB_REG_MSR: begin
				// modem inputs only reported, never gate the transmitter
				rd_byte              = 8'h00;
				rd_byte[DUB_MSR_CTS] = cts_s[rd_ch];
				rd_byte[DUB_MSR_DSR] = dsr_s[rd_ch];
			end
			default: begin
				rd_byte = regs[rd_ch][addr_s];
			end
		endcase
	end

	always_comb begin
		next_regs    = regs;
		next_rx_hold = rx_hold;
		next_tx_byte = O_TX_BYTE;
		next_tx_full = tx_full;
		next_rx_full = rx_full;
		next_dev_do  = dev_do;
		// drive only while a select and the read strobe are both low
		next_dev_oe  = ~rd_s & (|sel);
		if (rd_fall && (|sel)) begin
			next_dev_do = rd_byte;
			if (addr_s == DUB_REG_DATA) begin
				next_rx_full[rd_ch] = 1'b0;
			end
		end
		for (int c = 0; c < DUB_CHANS; c++) begin
			if (I_TX_TAKEN[c]) begin
				next_tx_full[c] = 1'b0;
			end
			// a load in the cycle of the reading access still counts
			if (I_RX_LOAD[c]) begin
				next_rx_full[c] = 1'b1;
				next_rx_hold[c] = I_RX_BYTE[c];
			end
			if (wr_rise && sel[c]) begin
				if (addr_s == DUB_REG_DATA) begin
					next_tx_byte[c] = data_s;
					next_tx_full[c] = 1'b1;
				end else if (addr_s != DUB_REG_LSR && addr_s != DUB_REG_MSR) begin
					next_regs[c][addr_s] = data_s;
				end
			end
			next_out2[c] = next_regs[c][DUB_REG_MDM][DUB_MDM_OUT2];
			next_rts[c]  = next_regs[c][DUB_REG_MDM][DUB_MDM_RTS];
			next_dtr[c]  = next_regs[c][DUB_REG_MDM][DUB_MDM_DTR];
		end
	end

	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			sync1       <= '1;
			sync2       <= '1;
			rd_prev     <= 1'b1;
			wr_prev     <= 1'b1;
			regs        <= {(2 * 8){DUB_REG_RST}};
			rx_hold     <= {2{DUB_REG_RST}};
			O_TX_BYTE   <= {2{DUB_REG_RST}};
			tx_full     <= 2'h0;
			rx_full     <= 2'h0;
			dev_do      <= DUB_BUS_IDLE;
			dev_oe      <= 1'b0;
			irq_q       <= 2'h0;
			out2        <= 2'h0;
			rts         <= 2'h0;
			dtr         <= 2'h0;
			ser_out     <= 2'h3;
			O_TX_VALID  <= 2'h0;
			O_SERIAL_IN <= 2'h3;
			O_CTS       <= 2'h0;
			O_DSR       <= 2'h0;
		end else if (I_CE) begin
			sync1       <= pins;
			sync2       <= sync1;
			rd_prev     <= rd_s;
			wr_prev     <= wr_s;
			regs        <= next_regs;
			rx_hold     <= next_rx_hold;
			O_TX_BYTE   <= next_tx_byte;
			tx_full     <= next_tx_full;
			rx_full     <= next_rx_full;
			dev_do      <= next_dev_do;
			dev_oe      <= next_dev_oe;
			irq_q       <= I_IRQ_REQ;
			out2        <= next_out2;
			rts         <= next_rts;
			dtr         <= next_dtr;
			ser_out     <= I_SERIAL_OUT;
			O_TX_VALID  <= next_tx_full;
			// an idle line reads high here; a silent sender must hold it so
			O_SERIAL_IN <= ser_in_s;
			O_CTS       <= cts_s;
			O_DSR       <= dsr_s;
		end
	end

	// pin outputs, each from a flip-flop, the aux, rx ready, request and terminal ready pins through an inverter
	assign BUS.dev_data_out            = dev_do;
	assign BUS.dev_data_oe             = dev_oe;
	assign BUS.chan_a_irq_out          = irq_q[0];
	assign BUS.chan_b_irq_out          = irq_q[1];
	assign BUS.chan_a_irq_oe           = out2[0];
	assign BUS.chan_b_irq_oe           = out2[1];
	assign BUS.chan_a_aux_out2_n       = ~out2[0];
	assign BUS.chan_b_aux_out2_n       = ~out2[1];
	assign BUS.chan_a_tx_ready_n       = O_TX_VALID[0];
	assign BUS.chan_b_tx_ready_n       = O_TX_VALID[1];
	assign BUS.chan_a_rx_ready_n       = ~rx_full[0];
	assign BUS.chan_b_rx_ready_n       = ~rx_full[1];
	assign BUS.chan_a_serial_out       = ser_out[0];
	assign BUS.chan_b_serial_out       = ser_out[1];
	assign BUS.chan_a_request_send_n   = ~rts[0];
	assign BUS.chan_b_request_send_n   = ~rts[1];
	assign BUS.chan_a_terminal_ready_n = ~dtr[0];
	assign BUS.chan_b_terminal_ready_n = ~dtr[1];
endmodule // dub_device

// file: rtl/dub_host.sv
// host end: turns single access requests into strobed bus cycles
module dub_host
	import dub_pkg::*;
#(
	parameter int STROBE_CYC = DUB_STROBE_CYC,
	parameter int HOLD_CYC   = DUB_HOLD_CYC
) (
	// clock, reset, enable
	input  wire logic        I_CLK,
	input  wire logic        I_RST_N,
	input  wire logic        I_CE,
	// bus pins
	dub_if.host              BUS,
	// access request
	input  wire logic        I_REQ,
	input  wire logic        I_WRITE,
	input  wire logic        I_CHAN,
	input  wire logic [2:0]  I_ADDR,
	input  wire logic [7:0]  I_WDATA,
	// answer
	output logic             O_BUSY,
	output logic             O_DONE,
	output logic [7:0]       O_RDATA,
	// sampled device status, active high
	output logic [1:0]       O_IRQ,
	output logic [1:0]       O_TX_READY,
	output logic [1:0]       O_RX_READY
);
	import dub_pkg::*;

	// the device samples pins through two flops, so short strobes would be missed
	if (STROBE_CYC < DUB_STROBE_MIN || STROBE_CYC > 255 || HOLD_CYC < DUB_HOLD_MIN
		|| HOLD_CYC > 255) begin : g_bad_timing
		$error("dub_host: strobe or hold count out of range");
	end

	logic [13:0]     sync1;
	logic [13:0]     sync2;
	dub_state_t      state;
	dub_state_t      next_state;
	logic [7:0]      cnt;
	logic [7:0]      next_cnt;
	logic            wr;
	logic            next_wr;
	logic [1:0]      cs_n;
	logic [1:0]      next_cs_n;
	logic [2:0]      addr;
	logic [2:0]      next_addr;
	logic [7:0]      dout;
	logic [7:0]      next_dout;
	logic            oe;
	logic            next_oe;
	logic            rd_n;
	logic            next_rd_n;
	logic            wr_n;
	logic            next_wr_n;
	logic [7:0]      next_rdata;
	logic            next_done;

	always_comb begin
		next_state = state;
		next_cnt   = cnt - 8'h01;
		next_wr    = wr;
		next_cs_n  = cs_n;
		next_addr  = addr;
		next_dout  = dout;
		next_oe    = oe;
		next_rd_n  = rd_n;
		next_wr_n  = wr_n;
		next_rdata = O_RDATA;
		next_done  = 1'b0;
		unique case (state)
			DUB_IDLE: begin
				next_cnt = 8'(DUB_SETUP_CYC - 1);
				if (I_REQ) begin
					next_state = DUB_SETUP;
					next_wr    = I_WRITE;
					// one select low for the whole access
					next_cs_n  = I_CHAN ? 2'h1 : 2'h2;
					next_addr  = I_ADDR;
					next_dout  = I_WDATA;
					next_oe    = I_WRITE;
				end
			end
			DUB_SETUP: begin
				if (cnt == 8'h00) begin
					next_state = DUB_STROBE;
					next_cnt   = 8'(STROBE_CYC - 1);
					next_rd_n  = wr;
					next_wr_n  = ~wr;
				end
			end
			DUB_STROBE: begin
				if (cnt == 8'h00) begin
					next_state = DUB_HOLD;
					next_cnt   = 8'(HOLD_CYC - 1);
					next_rd_n  = 1'b1;
					next_wr_n  = 1'b1;
					if (!wr) begin
						next_rdata = sync2[13:6];
					end
				end
			end
			DUB_HOLD: begin
				// data and select stay until the device has seen the rising edge
				if (cnt == 8'h00) begin
					next_state = DUB_IDLE;
					next_cs_n  = 2'h3;
					next_oe    = 1'b0;
					next_done  = 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			sync1      <= 14'h0000;
			sync2      <= 14'h0000;
			state      <= DUB_IDLE;
			cnt        <= 8'h00;
			wr         <= 1'b0;
			cs_n       <= 2'h3;
			addr       <= 3'h0;
			dout       <= 8'h00;
			oe         <= 1'b0;
			rd_n       <= 1'b1;
			wr_n       <= 1'b1;
			O_RDATA    <= 8'h00;
			O_DONE     <= 1'b0;
			O_BUSY     <= 1'b0;
			O_IRQ      <= 2'h0;
			O_TX_READY <= 2'h0;
			O_RX_READY <= 2'h0;
		end else if (I_CE) begin
			sync1      <= {BUS.data_bus, BUS.chan_b_irq_line, BUS.chan_a_irq_line,
				~BUS.chan_b_tx_ready_n, ~BUS.chan_a_tx_ready_n,
				~BUS.chan_b_rx_ready_n, ~BUS.chan_a_rx_ready_n};
			sync2      <= sync1;
			state      <= next_state;
			cnt        <= next_cnt;
			wr         <= next_wr;
			cs_n       <= next_cs_n;
			addr       <= next_addr;
			dout       <= next_dout;
			oe         <= next_oe;
			rd_n       <= next_rd_n;
			wr_n       <= next_wr_n;
			O_RDATA    <= next_rdata;
			O_DONE     <= next_done;
			O_BUSY     <= (next_state != DUB_IDLE);
			O_IRQ      <= sync2[5:4];
			O_TX_READY <= sync2[3:2];
			O_RX_READY <= sync2[1:0];
		end
	end

	assign BUS.addr            = addr;
	assign BUS.read_strobe_n   = rd_n;
	assign BUS.write_strobe_n  = wr_n;
	assign BUS.chan_a_select_n = cs_n[0];
	assign BUS.chan_b_select_n = cs_n[1];
	assign BUS.host_data_out   = dout;
	assign BUS.host_data_oe    = oe;
endmodule // dub_host

// file: testbench/dub_bus_assertions.sv
// concurrent checks on the pins between the host end and the device end
module dub_bus_assertions (
	// clock and reset
	input wire logic I_CLK,
	input wire logic I_RST_N,
	// bus pins
	input wire logic read_strobe_n,
	input wire logic write_strobe_n,
	input wire logic chan_a_select_n,
	input wire logic chan_b_select_n,
	input wire logic host_data_oe,
	input wire logic dev_data_oe,
	// channel pins
	input wire logic chan_a_irq_oe,
	input wire logic chan_b_irq_oe,
	input wire logic chan_a_aux_out2_n,
	input wire logic chan_b_aux_out2_n,
	input wire logic chan_a_tx_ready_n,
	input wire logic chan_b_rx_ready_n
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_RST_N);

	property p_read_start;
		$fell(read_strobe_n) && !(chan_a_select_n && chan_b_select_n) |-> ##[1:5] dev_data_oe;
	endproperty
	a_read_start: assert property (p_read_start) else $error("read not answered");
	property p_drive_start;
		$rose(dev_data_oe) |-> !$past(read_strobe_n);
	endproperty
	a_drive_start: assert property (p_drive_start) else $error("bus driven without read");
	property p_drive_sel;
		dev_data_oe |-> !(chan_a_select_n && chan_b_select_n);
	endproperty
	a_drive_sel: assert property (p_drive_sel) else $error("bus driven while deselected");
	property p_write_quiet;
		!write_strobe_n |-> host_data_oe && !dev_data_oe;
	endproperty
	a_write_quiet: assert property (p_write_quiet) else $error("bus clash in write");
	property p_strobe_len;
		$fell(write_strobe_n) |-> !write_strobe_n [*8];
	endproperty
	a_strobe_len: assert property (p_strobe_len) else $error("write strobe too short");
	property p_one_chan;
		$fell(read_strobe_n) || $fell(write_strobe_n) |-> chan_a_select_n != chan_b_select_n;
	endproperty
	a_one_chan: assert property (p_one_chan) else $error("select not one channel");
	property p_out2_a;
		chan_a_irq_oe != chan_a_aux_out2_n;
	endproperty
	a_out2_a: assert property (p_out2_a) else $error("channel A out2 pins disagree");
	property p_out2_b;
		chan_b_irq_oe != chan_b_aux_out2_n;
	endproperty
	a_out2_b: assert property (p_out2_b) else $error("channel B out2 pins disagree");
	property p_tx_busy;
		$rose(chan_a_tx_ready_n) |-> !$past(chan_a_select_n);
	endproperty
	a_tx_busy: assert property (p_tx_busy) else $error("tx ready lost without write");
	property p_rx_read;
		$rose(chan_b_rx_ready_n) |-> !$past(chan_b_select_n);
	endproperty
	a_rx_read: assert property (p_rx_read) else $error("rx ready lost without read");
endmodule // dub_bus_assertions

// file: testbench/dual_uart_host_bus_port_test.sv
// self-checking bench joining the host and device ends of the dual serial bus port
module dual_uart_host_bus_port_test;
	timeunit 1ns;
	timeprecision 1ns;
	import dub_pkg::*;
	logic            clk, rst_n, req, wr, chan, busy, done;
	logic [2:0]      addr;
	logic [7:0]      wdata, rdata, v;
	logic [1:0]      irq, txr, rxr, tx_valid, tx_taken, rx_load, irq_req, ser_out;
	logic [1:0]      ser_in, cts_n, dsr_n, ser_in_s, cts, dsr;
	logic [1:0][7:0] tx_byte, rx_byte;
	logic [8:0]      notes[$];
	logic [8:0]      note;
	logic [7:0]      st[2][4];
	logic [2:0]      sa[4] = '{3'h1, 3'h2, 3'h3, 3'h7};
	int              num_errors, tests_run, cycles, seed_out;
	wire  [1:0]      aux_n, irq_ln, rts_n, dtr_n, txr_n, rxr_n, sout;

	dub_if dub_if_i ();
	assign aux_n = {dub_if_i.chan_b_aux_out2_n, dub_if_i.chan_a_aux_out2_n};
	assign irq_ln = {dub_if_i.chan_b_irq_line, dub_if_i.chan_a_irq_line};
	assign rts_n = {dub_if_i.chan_b_request_send_n, dub_if_i.chan_a_request_send_n};
	assign dtr_n = {dub_if_i.chan_b_terminal_ready_n, dub_if_i.chan_a_terminal_ready_n};
	assign txr_n = {dub_if_i.chan_b_tx_ready_n, dub_if_i.chan_a_tx_ready_n};
	assign rxr_n = {dub_if_i.chan_b_rx_ready_n, dub_if_i.chan_a_rx_ready_n};
	assign sout = {dub_if_i.chan_b_serial_out, dub_if_i.chan_a_serial_out};
	assign {dub_if_i.chan_b_serial_in, dub_if_i.chan_a_serial_in} = ser_in;
	assign {dub_if_i.chan_b_clear_send_n, dub_if_i.chan_a_clear_send_n} = cts_n;
	assign {dub_if_i.chan_b_set_ready_n, dub_if_i.chan_a_set_ready_n} = dsr_n;

	dub_device dub_device_i (.I_CLK(clk), .I_RST_N(rst_n), .I_CE(1'b1), .BUS(dub_if_i),
		.O_TX_VALID(tx_valid), .O_TX_BYTE(tx_byte), .I_TX_TAKEN(tx_taken),
		.I_RX_BYTE(rx_byte), .I_RX_LOAD(rx_load), .I_IRQ_REQ(irq_req),
		.I_SERIAL_OUT(ser_out), .O_SERIAL_IN(ser_in_s), .O_CTS(cts), .O_DSR(dsr));
	dub_host dub_host_i (.I_CLK(clk), .I_RST_N(rst_n), .I_CE(1'b1), .BUS(dub_if_i),
		.I_REQ(req), .I_WRITE(wr), .I_CHAN(chan), .I_ADDR(addr), .I_WDATA(wdata),
		.O_BUSY(busy), .O_DONE(done), .O_RDATA(rdata), .O_IRQ(irq),
		.O_TX_READY(txr), .O_RX_READY(rxr));
	dub_bus_assertions dub_bus_assertions_i (.I_CLK(clk), .I_RST_N(rst_n),
		.read_strobe_n(dub_if_i.read_strobe_n), .write_strobe_n(dub_if_i.write_strobe_n),
		.chan_a_select_n(dub_if_i.chan_a_select_n), .chan_b_select_n(dub_if_i.chan_b_select_n),
		.host_data_oe(dub_if_i.host_data_oe), .dev_data_oe(dub_if_i.dev_data_oe),
		.chan_a_irq_oe(dub_if_i.chan_a_irq_oe), .chan_b_irq_oe(dub_if_i.chan_b_irq_oe),
		.chan_a_aux_out2_n(dub_if_i.chan_a_aux_out2_n),
		.chan_b_aux_out2_n(dub_if_i.chan_b_aux_out2_n),
		.chan_a_tx_ready_n(dub_if_i.chan_a_tx_ready_n),
		.chan_b_rx_ready_n(dub_if_i.chan_b_rx_ready_n));

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	// one host access; the note says whether the answer is compared
	task automatic access(input logic w, input logic c, input logic [2:0] a,
			input logic [7:0] d, input logic [8:0] n9);
		int n;
		@(posedge clk);
		req <= 1'b1;
		wr <= w;
		chan <= c;
		addr <= a;
		wdata <= d;
		notes.push_back(n9);
		@(posedge clk);
		req <= 1'b0;
		@(negedge clk);
		check(busy, 1'b1);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (done !== 1'b1 && n < 100);
		if (n >= 100) num_errors++;
		check(busy, 1'b0);
	endtask

	task automatic wr_reg(input logic c, input logic [2:0] a, input logic [7:0] d);
		access(1'b1, c, a, d, 9'h000);
	endtask

	task automatic rd_reg(input logic c, input logic [2:0] a, input logic [7:0] e);
		access(1'b0, c, a, 8'h00, {1'b1, e});
	endtask

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// hang guard: the whole sequence needs well under this many cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			num_errors++;
			stop_test();
		end
	end

	always @(negedge clk) begin
		if (done === 1'b1) begin
			note = notes.pop_front();
			if (note[8]) check(rdata, note[7:0]);
		end
	end

	initial begin
		{rst_n, req, wr, chan, addr, wdata, tx_taken, rx_load, irq_req, rx_byte} = '0;
		{ser_out, ser_in, cts_n, dsr_n} = '1;
		seed_out = $urandom(32'hD28D249C);
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		cyc(2);
		check(ser_in_s, 2'b11);
		check(txr_n, 2'b00);
		check(rxr_n, 2'b11);
		check(aux_n, 2'b11);
		check(dub_if_i.data_bus, 8'hFF);
		for (int c = 0; c < 2; c++) begin
			for (int m = 0; m < 2; m++) begin
				v = 8'($urandom);
				v[3] = m[0];
				wr_reg(c[0], DUB_REG_MDM, v);
				@(posedge clk);
				irq_req[c] <= 1'b1;
				cyc(6);
				check(aux_n[c], !v[3]);
				check(irq_ln[c], v[3]);
				check(irq[c], v[3]);
				check(rts_n[c], !v[1]);
				check(dtr_n[c], !v[0]);
				@(posedge clk);
				irq_req[c] <= 1'b0;
			end
		end
		// fill both channels before reading back so cross-channel writes show
		for (int c = 0; c < 2; c++) begin
			for (int i = 0; i < 4; i++) begin
				st[c][i] = 8'($urandom);
				wr_reg(c[0], sa[i], st[c][i]);
			end
		end
		for (int c = 0; c < 2; c++) begin
			for (int i = 0; i < 4; i++) rd_reg(c[0], sa[i], st[c][i]);
		end
		check(dub_if_i.data_bus, 8'hFF);
		for (int c = 0; c < 2; c++) begin
			v = 8'($urandom);
			wr_reg(c[0], DUB_REG_DATA, v);
			cyc(2);
			check(tx_valid[c], 1'b1);
			check(tx_byte[c], v);
			check(txr_n[c], 1'b1);
			@(posedge clk);
			tx_taken[c] <= 1'b1;
			@(posedge clk);
			tx_taken[c] <= 1'b0;
			cyc(5);
			check(txr_n[c], 1'b0);
			check(txr[c], 1'b1);
			@(posedge clk);
			rx_byte[c] <= ~v;
			rx_load[c] <= 1'b1;
			@(posedge clk);
			rx_load[c] <= 1'b0;
			cyc(5);
			check(rxr_n[c], 1'b0);
			check(rxr[c], 1'b1);
			rd_reg(c[0], DUB_REG_LSR, 8'h21);
			rd_reg(c[0], DUB_REG_DATA, ~v);
			cyc(2);
			check(rxr_n[c], 1'b1);
		end
		for (int k = 0; k < 8; k++) begin
			@(posedge clk);
			cts_n[k[2]] <= k[0];
			dsr_n[k[2]] <= k[1];
			ser_in[k[2]] <= k[0] ^ k[1];
			ser_out <= k[1:0];
			cyc(5);
			check(cts[k[2]], !k[0]);
			check(dsr[k[2]], !k[1]);
			check(ser_in_s[k[2]], k[0] ^ k[1]);
			check(sout, k[1:0]);
			rd_reg(k[2], DUB_REG_MSR, {2'b00, !k[1], !k[0], 4'h0});
		end
		stop_test();
	end
endmodule // dual_uart_host_bus_port_test
